// File: rtl/lsm_mapper.v
// lane sample mapper: collects channel samples and spreads them over up to eight lanes
`include "lsm_defs.vh"
`default_nettype none

module lsm_mapper #(
   parameter CHANNELS = 4
) (
   // clock and reset
   input wire REF_CLK,
   input wire RST_N,
   // configuration
   input wire [3:0] LANE_MAP_MODE,
   // converter samples, one per channel per strobe
   input wire SAMPLE_VALID,
   input wire [8:0] SAMPLE_A,
   input wire [8:0] SAMPLE_B,
   input wire [8:0] SAMPLE_C,
   input wire [8:0] SAMPLE_D,
   // lane octets, lane n in bits 8n+7..8n
   output wire [63:0] LANE_DATA,
   output wire [7:0] LANE_VALID,
   output wire [7:0] LANE_FIRST,
   // status
   output reg [7:0] LANE_ACTIVE,
   output reg MODE_ERR
);

   // one-hot collect states
   localparam ST_IDLE = 3'h1;
   localparam ST_FILL = 3'h2;
   localparam ST_LOAD = 3'h4;

   localparam NSLOT = 4 * `LSM_SLOTS;

   // lane sets of the variant: lane-pair modes use two lanes per channel,
   // the grouped mode four; a quad part never reaches the grouped set
   localparam [7:0] SET_PAIR = (CHANNELS == 4) ? 8'hff : (CHANNELS == 2) ? 8'h0f : 8'h03;
   localparam [7:0] SET_QUAD = (CHANNELS == 2) ? 8'hff : 8'h0f;

   // collect sequence and the mode held for the block being filled
   reg [2:0] state_q;
   reg [2:0] state_d;
   reg [3:0] mode_q;
   reg [4:0] cnt_q;
   reg [4:0] cnt_d;

   // sample store: no reset, it only holds data that each block overwrites
   reg [8:0] samp_q [0:NSLOT-1];

   // layout of the held mode
   reg [4:0] need;
   reg [3:0] octets;
   reg [7:0] active;

   // mode check and store write port
   reg in_ok;
   reg wr_en;
   reg [4:0] wr_idx;

   // all channel inputs side by side, channel A lowest
   wire [35:0] samp_in;
   wire load;
   integer ch;

   assign samp_in = {SAMPLE_D, SAMPLE_C, SAMPLE_B, SAMPLE_A};
   assign load = state_q[2];

   // is the requested mode legal for this variant; mode 11 is refused on quad parts
   always @* begin
      case (LANE_MAP_MODE)
         `LSM_MODE_8B1: in_ok = 1'b1;
         `LSM_MODE_9B10: in_ok = 1'b1;
         `LSM_MODE_9B12: in_ok = (CHANNELS < 4); // [RULE6]
         default: in_ok = 1'b0;
      endcase
   end

   // block size, octet count and lane set of the held mode
   always @* begin
      case (mode_q)
         `LSM_MODE_8B1: begin
            need = `LSM_BLK_8B1;
            octets = `LSM_OCT_8B1; // [RULE2]
            active = SET_PAIR; // [RULE1]
         end
         `LSM_MODE_9B10: begin
            need = `LSM_BLK_9B10;
            octets = `LSM_OCT_9B10; // [RULE4]
            active = SET_PAIR; // [RULE5]
         end
         `LSM_MODE_9B12: begin
            need = `LSM_BLK_9B12;
            octets = `LSM_OCT_9B12; // [RULE7]
            active = SET_QUAD; // [RULE6] [RULE8]
         end
         default: begin
            need = `LSM_BLK_8B1;
            octets = 4'h0;
            active = 8'h00;
         end
      endcase
   end

   // collect sequence; a strobe in the load cycle opens the next block at once
   always @* begin
      state_d = state_q;
      cnt_d = cnt_q;
      wr_en = 1'b0;
      wr_idx = cnt_q;
      case (state_q)
         ST_IDLE, ST_LOAD: begin
            wr_idx = 5'h00;
            if (SAMPLE_VALID && in_ok) begin
               wr_en = 1'b1;
               cnt_d = 5'h01;
               state_d = ST_FILL;
            end else begin
               cnt_d = 5'h00;
               state_d = ST_IDLE;
            end
         end
         ST_FILL: begin
            if (SAMPLE_VALID) begin
               wr_en = 1'b1;
               cnt_d = cnt_q + 5'h01;
               if (cnt_q == need - 5'h01) begin
                  state_d = ST_LOAD;
               end
            end
         end
         default: begin
            state_d = ST_IDLE;
            cnt_d = 5'h00;
         end
      endcase
   end

   // control registers; mode is only taken between blocks so a block never mixes layouts
   always @(posedge REF_CLK) begin
      if (!RST_N) begin
         state_q <= ST_IDLE;
         cnt_q <= 5'h00;
         mode_q <= 4'h0;
         MODE_ERR <= 1'b0;
         LANE_ACTIVE <= 8'h00;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         MODE_ERR <= ~in_ok; // [RULE6]
         if (state_q != ST_FILL) begin
            mode_q <= LANE_MAP_MODE;
         end
         if (load) begin
            LANE_ACTIVE <= active;
         end
      end
   end

   // sample store: channel ch sample n sits in slot ch*20+n; absent channels are skipped
   always @(posedge REF_CLK) begin
      if (wr_en) begin
         for (ch = 0; ch < 4; ch = ch + 1) begin
            if (ch < CHANNELS) begin
               samp_q[ch * `LSM_SLOTS + wr_idx] <= samp_in[ch * 9 +: 9];
            end
         end
      end
   end

   // per-lane octet layout and packer
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : lane
         // pair lanes by channel in modes 9 and 10, groups of four in mode 11
         localparam integer C2 = (g / 2) * `LSM_SLOTS + (g % 2);
         localparam integer C4 = (g / 4) * `LSM_SLOTS + (g % 4);
         wire [63:0] w_8b1;
         wire [63:0] w_9b10;
         wire [63:0] w_9b12;
         reg [63:0] word;

         // one octet per lane, top eight bits of the sample kept
         assign w_8b1 = {samp_q[C2][8:1], 56'h0}; // [RULE2] [RULE3]

         // even or odd samples of the pair, each with one trailing zero
         assign w_9b10 = {samp_q[C2], `LSM_PAD1, samp_q[C2 + 2], `LSM_PAD1,
                          samp_q[C2 + 4], `LSM_PAD1, samp_q[C2 + 6], `LSM_PAD1,
                          24'h0}; // [RULE4] [RULE5]

         // five samples four apart, three zeros each, then the tail nibble
         assign w_9b12 = {samp_q[C4], `LSM_PAD3, samp_q[C4 + 4], `LSM_PAD3,
                          samp_q[C4 + 8], `LSM_PAD3, samp_q[C4 + 12], `LSM_PAD3,
                          samp_q[C4 + 16], `LSM_PAD3, `LSM_TAIL}; // [RULE7] [RULE8]

         // layout select; the packer takes it only in the load cycle, so later changes are harmless
         always @* begin
            case (mode_q)
               `LSM_MODE_8B1: word = w_8b1;
               `LSM_MODE_9B10: word = w_9b10;
               `LSM_MODE_9B12: word = w_9b12;
               default: word = 64'h0;
            endcase
         end

         // lanes outside the variant's set are never loaded and stay silent
         lsm_lane_packer #(
            .WORD_W(64)
         ) u_pack (
            .clk(REF_CLK),
            .rst_n(RST_N),
            .load(load & active[g]), // [RULE3] [RULE8]
            .word(word),
            .octets(octets),
            .octet_q(LANE_DATA[g * 8 +: 8]),
            .valid_q(LANE_VALID[g]),
            .first_q(LANE_FIRST[g])
         );
      end
   endgenerate

endmodule // lsm_mapper

`default_nettype wire

// File: rtl/lsm_defs.vh
// constants for the lane sample mapper, lane-map modes 9 to 11
//
// Behaviour
// RULE1: mode 9 sends 8-bit samples on 8B/10B lanes: eight, four or two lanes.
// RULE2: mode 9 puts one sample per lane octet; lane 0 A0, lane 1 A1.
// RULE3: mode 9 lanes 2-3 carry B0/B1; lanes 4-7 carry C and D, quad only.
// RULE4: mode 10 pads 9-bit samples with one zero; four fill five octets per lane.
// RULE5: mode 10 lane pair per channel: even samples first lane, odd second, A-D.
// RULE6: mode 11 only dual/single, eight or four lanes, samples padded with 000.
// RULE7: mode 11 lane k carries samples k,k+4,k+8,k+12,k+16 then a tail nibble.
// RULE8: mode 11 lanes 0-3 carry channel A; lanes 4-7 carry channel B, dual only.
// RULE9: receiver strips padding and tail, then undoes the lane interleave; the lsm_rx model keeps padding and lane order.
`ifndef LSM_DEFS_VH
`define LSM_DEFS_VH

// lane-map mode codes
`define LSM_MODE_8B1 4'h9
`define LSM_MODE_9B10 4'ha
`define LSM_MODE_9B12 4'hb

// samples per channel that make up one block in each mode
`define LSM_BLK_8B1 5'h02
`define LSM_BLK_9B10 5'h08
`define LSM_BLK_9B12 5'h14

// octets sent per lane for one block
`define LSM_OCT_8B1 4'h1
`define LSM_OCT_9B10 4'h5
`define LSM_OCT_9B12 4'h8

// storage slots reserved per channel (largest block)
`define LSM_SLOTS 5'h14

// padding and tail values
`define LSM_PAD1 1'b0
`define LSM_PAD3 3'h0
`define LSM_TAIL 4'h0

`endif

// File: rtl/lsm_lane_packer.v
// one lane: shifts a loaded block out as octets, most significant first
`default_nettype none

module lsm_lane_packer #(
   parameter WORD_W = 64
) (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // block load
   input wire load,
   input wire [WORD_W-1:0] word,
   input wire [3:0] octets,
   // octet output
   output reg [7:0] octet_q,
   output reg valid_q,
   output reg first_q
);

   reg [WORD_W-1:0] sh_q;
   reg [3:0] left_q;
   reg first_pend_q;

   // a load always wins; within one mode the previous block has drained by then
   always @(posedge clk) begin
      if (!rst_n) begin
         sh_q <= {WORD_W{1'b0}};
         left_q <= 4'h0;
         first_pend_q <= 1'b0;
         octet_q <= 8'h00;
         valid_q <= 1'b0;
         first_q <= 1'b0;
      end else if (load) begin
         sh_q <= word;
         left_q <= octets;
         first_pend_q <= 1'b1;
         valid_q <= 1'b0;
         first_q <= 1'b0;
      end else if (left_q != 4'h0) begin
         octet_q <= sh_q[WORD_W-1:WORD_W-8];
         sh_q <= {sh_q[WORD_W-9:0], 8'h00};
         left_q <= left_q - 4'h1;
         valid_q <= 1'b1;
         first_q <= first_pend_q;
         first_pend_q <= 1'b0;
      end else begin
         valid_q <= 1'b0;
         first_q <= 1'b0;
      end
   end

endmodule // lsm_lane_packer

`default_nettype wire

// File: sim/lsm_mapper_asserts.sv
// port assertions for the lane sample mapper
`default_nettype none
module lsm_mapper_asserts #(parameter CHANNELS = 4) (
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RST_N,
   // inputs
   input wire logic [3:0] LANE_MAP_MODE,
   input wire logic [8:0] SAMPLE_A,
   // outputs
   input wire logic [63:0] LANE_DATA,
   input wire logic [7:0] LANE_VALID,
   input wire logic [7:0] LANE_FIRST,
   input wire logic MODE_ERR
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   localparam logic [7:0] M2 = 8'hff >> (8 - 2 * CHANNELS);
   localparam logic [7:0] M4 = 8'hff >> (8 - 4 * CHANNELS);
   // block starts per mode; mode is only changed while lanes are quiet
   wire logic f9 = LANE_FIRST[0] && LANE_MAP_MODE == 4'h9;
   wire logic fa = LANE_FIRST[0] && LANE_MAP_MODE == 4'ha;
   wire logic fb = LANE_FIRST[0] && LANE_MAP_MODE == 4'hb;
   wire logic ok = LANE_MAP_MODE inside {4'h9, 4'ha} || (LANE_MAP_MODE == 4'hb && CHANNELS < 4);
   wire logic [7:0] a8 = SAMPLE_A[8:1];
   property p_lanes9; f9 |-> LANE_VALID == M2 ##1 LANE_VALID == 8'h00; endproperty
   a_lanes9: assert property (p_lanes9) else $error("lane set");
   property p_data9; f9 |-> LANE_DATA[15:0] == {$past(a8, 3), $past(a8, 4)}; endproperty
   a_data9: assert property (p_data9) else $error("octet");
   property p_len10; fa |-> LANE_VALID[0] [*5] ##1 !LANE_VALID[0]; endproperty
   a_len10: assert property (p_len10) else $error("length");
   property p_pad10; fa |-> ##1 LANE_DATA[6] == 1'b0; endproperty
   a_pad10: assert property (p_pad10) else $error("pad");
   property p_len11; fb |-> LANE_VALID[0] [*8] ##1 !LANE_VALID[0]; endproperty
   a_len11: assert property (p_len11) else $error("length");
   property p_tail11; fb |-> ##1 LANE_DATA[6:4] == 3'h0 ##6 LANE_DATA[3:0] == 4'h0; endproperty
   a_tail11: assert property (p_tail11) else $error("tail");
   property p_set11; fb |-> LANE_FIRST == M4; endproperty
   a_set11: assert property (p_set11) else $error("lane set");
   property p_err; $past(RST_N) |-> MODE_ERR == !$past(ok); endproperty
   a_err: assert property (p_err) else $error("mode error");
endmodule // lsm_mapper_asserts
bind lsm_mapper lsm_mapper_asserts #(.CHANNELS(CHANNELS)) lsm_mapper_asserts_inst (
   .REF_CLK(REF_CLK), .RST_N(RST_N), .LANE_MAP_MODE(LANE_MAP_MODE), .SAMPLE_A(SAMPLE_A),
   .LANE_DATA(LANE_DATA), .LANE_VALID(LANE_VALID), .LANE_FIRST(LANE_FIRST), .MODE_ERR(MODE_ERR));
`default_nettype wire

// File: sim/lsm_rx.sv
// receiver model: gathers each lane's octets of a block into one word
`default_nettype none
module lsm_rx (
   // clock
   input wire logic clk,
   // lanes
   input wire logic [63:0] lane_data,
   input wire logic [7:0] lane_valid,
   input wire logic [7:0] lane_first,
   // gathered block
   output logic [63:0] word_q [8],
   output logic done
);
   timeunit 1ns;
   timeprecision 1ns;
   logic v0_q;
   // lane 0 is used in every mode, so its end marks the block end
   assign done = v0_q & ~lane_valid[0];
   // padding is left in place so the bench sees the raw layout
   always @(posedge clk) begin
      v0_q <= lane_valid[0];
      for (int l = 0; l < 8; l++) begin
         if (lane_first[l]) begin
            word_q[l] <= {56'h0, lane_data[8*l +: 8]};
         end else if (lane_valid[l]) begin
            word_q[l] <= {word_q[l][55:0], lane_data[8*l +: 8]};
         end
      end
   end
endmodule // lsm_rx
`default_nettype wire

// File: sim/lsm_mapper_bench.sv
// self-checking bench for the lane sample mapper, dual variant
`default_nettype none
module lsm_mapper_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst_n = 0, sv = 0;
   logic [3:0] mode = 4'h9;
   logic [8:0] sa = 0, sb = 0, sc = 0;
   wire logic [63:0] ld;
   wire logic [7:0] lv, lf, la;
   wire logic err, done;
   logic [63:0] w [8];
   logic [63:0] exp_q [$];
   int nl_q [$];
   int n_mismatch = 0, cmp_count = 0;
   lsm_mapper #(.CHANNELS(2)) lsm_mapper_inst (.REF_CLK(clk), .RST_N(rst_n),
      .LANE_MAP_MODE(mode), .SAMPLE_VALID(sv), .SAMPLE_A(sa), .SAMPLE_B(sb),
      .SAMPLE_C(sc), .SAMPLE_D(~sc), .LANE_DATA(ld), .LANE_VALID(lv),
      .LANE_FIRST(lf), .LANE_ACTIVE(la), .MODE_ERR(err));
   lsm_rx lsm_rx_inst (.clk(clk), .lane_data(ld), .lane_valid(lv), .lane_first(lf),
      .word_q(w), .done(done));
   initial forever #50 clk = ~clk;
   task automatic report_and_stop;
      $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t got %h want %h", $time, got, exp);
      end
   endtask
   // drives one block and notes each active lane's expected word
   task automatic blk(input logic [3:0] m);
      logic [8:0] a [20], b [20];
      int n, ln, wd;
      logic [63:0] v;
      n = (m == 4'h9) ? 2 : (m == 4'ha) ? 8 : 20;
      ln = (m == 4'hb) ? 4 : 2;
      wd = (m == 4'h9) ? 8 : (m == 4'ha) ? 10 : 12;
      for (int i = 0; i < n; i++) begin
         a[i] = 9'($urandom);
         b[i] = 9'($urandom);
         @(posedge clk);
         sv <= 1'b1;
         sa <= a[i];
         sb <= b[i];
         sc <= 9'($urandom);
      end
      nl_q.push_back(2 * ln);
      for (int l = 0; l < 2 * ln; l++) begin
         v = 0;
         for (int j = 0; j < n / ln; j++) begin
            v = (v << wd) | ((64'((l < ln) ? a[l%ln+j*ln] : b[l%ln+j*ln]) << 3) >> (12 - wd));
         end
         exp_q.push_back((m == 4'hb) ? v << 4 : v);
      end
   endtask
   // waits, bounded, until every noted block has been seen
   task automatic drain;
      int t;
      t = 0;
      while (nl_q.size() > 0 && t < 100) begin
         @(posedge clk);
         t++;
      end
      if (nl_q.size() > 0) begin
         n_mismatch++;
         $display("MISMATCH %0t block missing", $time);
         report_and_stop;
      end else @(posedge clk);
   endtask
   // compares each finished block against the oldest note
   always @(posedge clk) begin
      if (done === 1'b1) begin
         if (nl_q.size() == 0) begin
            n_mismatch++;
            $display("MISMATCH %0t block not expected", $time);
         end else begin
            check(64'(la), (64'h1 << nl_q[0]) - 64'h1);
            for (int l = 0; l < nl_q[0]; l++) begin
               check(w[l], exp_q.pop_front());
            end
            void'(nl_q.pop_front());
         end
      end
   end
   initial begin
      void'($urandom(32'h988f31e2));
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      // back-to-back blocks in each mode; mode changes only when idle
      for (int i = 0; i < 3; i++) begin
         mode <= 4'h9 + 4'(i);
         repeat (2) blk(4'h9 + 4'(i));
         @(posedge clk);
         sv <= 1'b0;
         drain;
         check(64'(err), 64'h0);
      end
      // strobes under an illegal mode are ignored and flagged
      mode <= 4'h3;
      sv <= 1'b1;
      repeat (4) @(posedge clk);
      check(64'(err), 64'h1);
      sv <= 1'b0;
      repeat (20) @(posedge clk);
      report_and_stop;
   end
endmodule // lsm_mapper_bench
`default_nettype wire
